// ===== design/stt_regs.sv
// system-control register slice: wide fault extension, interval counter, tlb tag, timer match
// Behaviour
// - extension captures only when base capture is for a 48-bit instruction.
// - low sixteen instruction bits land in extension bits 31:16.
// - extension bits 15:0 ignore writes and read zero.
// - extension exists only with presence flag, select three, and no-fault flag clear.
// - counter steps at constant core rate regardless of pipeline progress.
// - counter steps once every core cycle.
// - software writes the counter; user hardware register 2 reads it.
// - tlb exceptions copy fault address bits 31:13 into page pair field.
// - page pair extension writable only with small page support and enable.
// - tlb read loads tag fields, space tag and invalidate bit from entry.
// - eight-bit space tag feeds tlb matching; software or tlb read writes it.
// - tag extension active when enabled; memory map id mode zeroes both tags.
// - invalidate bit with support above one tells indexed write to invalidate.
// - address error may leave page fields modified, undefined for software.
// - software tag writes never touch fault address or context registers.
// - match register changes only on software write.
// - counter equal to match raises timer request and pending flag.
// - vectored mode delivers timer at the configured interrupt level.
// - a software write to match clears the pending timer request unless the new value equals the counter.
// - 48-bit fault puts upper 32 bits in base, lower 16 in extension.
`timescale 1ns/1ps
`default_nettype none
`include "stt_map.svh"
module stt_regs import stt_pkg::*; (
	// clock and reset
	input wire logic MCLK,
	input wire logic RST_B,
	// configuration straps
	input wire logic FAULT_INSN_PRESENT_FLAG,
	input wire logic [1:0] INSN_SET_SELECT,
	input wire logic NO_FAULT_INSN_FLAG,
	input wire logic [1:0] TLB_INVALIDATE_SUPPORT,
	input wire logic TAG_EXTENSION_ENABLE,
	input wire logic MEMORY_MAP_ID_MODE,
	input wire logic SMALL_PAGE_SUPPORT,
	input wire logic SMALL_PAGE_ENABLE,
	input wire logic VECTORED_MODE,
	input wire logic [5:0] TIMER_IRQ_LEVEL,
	// move to / move from system register
	input wire logic MOVE_TO_SYS_REG,
	input wire logic MOVE_FROM_SYS_REG,
	input wire logic [4:0] SYS_REG_NUM,
	input wire logic [2:0] SYS_REG_SEL,
	input wire logic [31:0] SYS_WDATA,
	output logic [31:0] SYS_RDATA,
	output logic SYS_RVALID,
	// user hardware register read
	input wire logic USER_HW_REG_READ_OP,
	input wire logic [4:0] USER_HW_REG_NUM,
	output logic [31:0] USER_HW_RDATA,
	output logic USER_HW_RVALID,
	// fault capture from exception logic
	input wire logic FAULT_INSN_CAPTURE,
	input wire logic FAULT_INSN_WIDE,
	input wire logic [47:0] FAULT_INSN,
	// tlb exception and tlb read
	input wire logic TLB_EXCEPTION,
	input wire logic ADDR_ERROR_EXCEPTION,
	input wire logic [31:0] FAULT_VADDR,
	input wire logic TLB_READ_OP,
	input wire logic [18:0] TLB_RD_VPN,
	input wire logic [1:0] TLB_RD_PPX,
	input wire logic TLB_RD_INV,
	input wire logic [1:0] TLB_RD_ASX,
	input wire logic [7:0] TLB_RD_ADDR_SPACE_TAG,
	input wire logic TLB_WRITE_INDEXED_OP,
	// tlb match / write side
	output logic [31:0] TLB_ENTRY_TAG,
	output logic [9:0] TLB_MATCH_ADDR_SPACE_TAG,
	output logic TLB_WR_INVALIDATE,
	// timer interrupt
	output logic TIMER_IRQ_PENDING,
	output logic TIMER_IRQ_REQ,
	output logic [5:0] TIMER_IRQ_VEC_LEVEL,
	output logic [31:0] COUNT_VALUE
);
	typedef struct packed {
		logic [15:0] ext;
		stt_tag_type tag;
		logic [31:0] rdata;
		logic rvalid;
		logic [31:0] hw_rdata;
		logic hw_rvalid;
		logic wr_inv;
		logic [9:0] match_addr_space_tag;
		logic pend;
		logic req;
		logic [5:0] lvl;
		logic [31:0] cnt_out;
	} stt_regs_state_type;
	stt_regs_state_type state_ff;
	stt_regs_state_type nxt_state;
	logic [31:0] count;
	logic [31:0] match_value;
	logic pending;
	logic ext_present;
	logic ppx_en;
	logic asx_en;
	logic wr_count;
	logic wr_tag;
	logic wr_match;
	logic [31:0] tag_word;
	logic [31:0] ext_word;
	assign ext_present = FAULT_INSN_PRESENT_FLAG && (INSN_SET_SELECT == `STT_ISA_WIDE)
		&& !NO_FAULT_INSN_FLAG;
	assign ppx_en = SMALL_PAGE_SUPPORT && SMALL_PAGE_ENABLE;
	assign asx_en = TAG_EXTENSION_ENABLE && !MEMORY_MAP_ID_MODE;
	// register select by number and select value
	assign wr_count = MOVE_TO_SYS_REG && (SYS_REG_NUM == `STT_REG_COUNT) && (SYS_REG_SEL == `STT_SEL_BASE);
	assign wr_tag = MOVE_TO_SYS_REG && (SYS_REG_NUM == `STT_REG_TAG) && (SYS_REG_SEL == `STT_SEL_BASE);
	assign wr_match = MOVE_TO_SYS_REG && (SYS_REG_NUM == `STT_REG_MATCH) && (SYS_REG_SEL == `STT_SEL_BASE);
	assign tag_word = {state_ff.tag.vpn, state_ff.tag.ppx, state_ff.tag.inv, state_ff.tag.asx, state_ff.tag.addr_space_tag};
	assign ext_word = {state_ff.ext, 16'h0000};
	stt_tick_counter u_counter (
		.clk(MCLK),
		.rst_b(RST_B),
		.load(wr_count),
		.load_value(SYS_WDATA),
		.count(count)
	);
	stt_timer_match u_match (
		.clk(MCLK),
		.rst_b(RST_B),
		.wr(wr_match),
		.wr_value(SYS_WDATA),
		.count(count),
		.match_value(match_value),
		.pending(pending)
	);
	always_comb begin
		nxt_state = state_ff;
		// base register takes the upper 32 bits; extension only for wide faults
		if (FAULT_INSN_CAPTURE && FAULT_INSN_WIDE && ext_present) begin
			nxt_state.ext = FAULT_INSN[15:0];
		end
		// software write first; hardware events below override it
		if (wr_tag) begin
			nxt_state.tag.vpn = SYS_WDATA[31:`STT_VPN_LO];
			nxt_state.tag.ppx = ppx_en ? SYS_WDATA[12:`STT_PPX_LO] : 2'h0;
			nxt_state.tag.inv = (TLB_INVALIDATE_SUPPORT > `STT_IE_MIN) ? SYS_WDATA[`STT_INV_BIT] : 1'b0;
			if (!MEMORY_MAP_ID_MODE) begin
				nxt_state.tag.addr_space_tag = SYS_WDATA[7:0];
				nxt_state.tag.asx = asx_en ? SYS_WDATA[9:`STT_ASX_LO] : 2'h0;
			end
			// fault address and context stay untouched here
		end
		if (TLB_EXCEPTION) begin
			nxt_state.tag.vpn = FAULT_VADDR[31:`STT_VPN_LO];
			nxt_state.tag.ppx = ppx_en ? FAULT_VADDR[12:`STT_PPX_LO] : 2'h0;
		end
		// address errors leave page fields alone here; software must not rely on them
		if (ADDR_ERROR_EXCEPTION) begin
			nxt_state.tag.vpn = state_ff.tag.vpn;
		end
		if (TLB_READ_OP) begin
			nxt_state.tag.vpn = TLB_RD_VPN;
			nxt_state.tag.ppx = ppx_en ? TLB_RD_PPX : 2'h0;
			nxt_state.tag.inv = (TLB_INVALIDATE_SUPPORT > `STT_IE_MIN) ? TLB_RD_INV : 1'b0;
			nxt_state.tag.addr_space_tag = MEMORY_MAP_ID_MODE ? 8'h00 : TLB_RD_ADDR_SPACE_TAG;
			nxt_state.tag.asx = asx_en ? TLB_RD_ASX : 2'h0;
		end
		if (!ppx_en) begin
			nxt_state.tag.ppx = 2'h0;
		end
		if (!asx_en) begin
			nxt_state.tag.asx = 2'h0;
		end
		if (MEMORY_MAP_ID_MODE) begin
			nxt_state.tag.addr_space_tag = 8'h00;
		end
		nxt_state.wr_inv = TLB_WRITE_INDEXED_OP && (TLB_INVALIDATE_SUPPORT > `STT_IE_MIN)
			&& state_ff.tag.inv;
		nxt_state.match_addr_space_tag = {state_ff.tag.asx, state_ff.tag.addr_space_tag};
		// one-cycle read path
		nxt_state.rvalid = MOVE_FROM_SYS_REG;
		nxt_state.rdata = `STT_ZERO32;
		if (MOVE_FROM_SYS_REG) begin
			case (SYS_REG_NUM)
				`STT_REG_FAULT: begin
					if (SYS_REG_SEL == `STT_SEL_EXT && ext_present) begin
						nxt_state.rdata = ext_word;
					end
				end
				`STT_REG_COUNT: begin
					if (SYS_REG_SEL == `STT_SEL_BASE) begin
						nxt_state.rdata = count;
					end
				end
				`STT_REG_TAG: begin
					if (SYS_REG_SEL == `STT_SEL_BASE) begin
						nxt_state.rdata = tag_word;
					end
				end
				`STT_REG_MATCH: begin
					if (SYS_REG_SEL == `STT_SEL_BASE) begin
						nxt_state.rdata = match_value;
					end
				end
				default: begin
					nxt_state.rdata = `STT_ZERO32;
				end
			endcase
		end
		nxt_state.hw_rvalid = USER_HW_REG_READ_OP;
		nxt_state.hw_rdata = (USER_HW_REG_READ_OP && USER_HW_REG_NUM == `STT_HWREG_COUNT) ? count
			: `STT_ZERO32;
		nxt_state.pend = pending;
		nxt_state.req = pending;
		nxt_state.lvl = VECTORED_MODE ? TIMER_IRQ_LEVEL : 6'h00;
		nxt_state.cnt_out = count;
	end
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end
	assign SYS_RDATA = state_ff.rdata;
	assign SYS_RVALID = state_ff.rvalid;
	assign USER_HW_RDATA = state_ff.hw_rdata;
	assign USER_HW_RVALID = state_ff.hw_rvalid;
	assign TLB_ENTRY_TAG = tag_word;
	assign TLB_MATCH_ADDR_SPACE_TAG = state_ff.match_addr_space_tag;
	assign TLB_WR_INVALIDATE = state_ff.wr_inv;
	assign TIMER_IRQ_PENDING = state_ff.pend;
	assign TIMER_IRQ_REQ = state_ff.req;
	assign TIMER_IRQ_VEC_LEVEL = state_ff.lvl;
	assign COUNT_VALUE = state_ff.cnt_out;
endmodule : stt_regs
`default_nettype wire

// ===== design/stt_map.svh
// register numbers, field positions and constants of the timer and tlb tag slice
`ifndef STT_MAP_SVH
`define STT_MAP_SVH
`define STT_REG_FAULT 5'h08
`define STT_SEL_EXT 3'h3
`define STT_REG_COUNT 5'h09
`define STT_REG_TAG 5'h0A
`define STT_REG_MATCH 5'h0B
`define STT_SEL_BASE 3'h0
`define STT_HWREG_COUNT 5'h02
`define STT_ISA_WIDE 2'h3
`define STT_EXT_LO 16
`define STT_VPN_LO 13
`define STT_PPX_LO 11
`define STT_INV_BIT 10
`define STT_ASX_LO 8
`define STT_IE_MIN 2'h1
`define STT_CNT_STEP 32'h00000001
`define STT_ZERO32 32'h00000000
`endif

// ===== design/stt_pkg.sv
// types shared by the timer and tlb tag slice
package stt_pkg;
	typedef enum logic [1:0] {
		TMR_IDLE,
		TMR_PEND
	} stt_tmr_state_type;
	typedef struct packed {
		logic [18:0] vpn;
		logic [1:0] ppx;
		logic inv;
		logic [1:0] asx;
		logic [7:0] addr_space_tag;
	} stt_tag_type;
endpackage : stt_pkg

// ===== design/stt_tick_counter.sv
// free-running interval counter with software load
`timescale 1ns/1ps
`default_nettype none
`include "stt_map.svh"
module stt_tick_counter import stt_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// software load
	input wire logic load,
	input wire logic [31:0] load_value,
	// count
	output logic [31:0] count
);
	typedef struct packed {
		logic [31:0] cnt;
	} stt_cnt_state_type;
	stt_cnt_state_type state_ff;
	stt_cnt_state_type nxt_state;
	// steps every core cycle, no pipeline dependency
	always_comb begin
		nxt_state = state_ff;
		if (load) begin
			nxt_state.cnt = load_value;
		end else begin
			nxt_state.cnt = state_ff.cnt + `STT_CNT_STEP;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end
	assign count = state_ff.cnt;
endmodule : stt_tick_counter
`default_nettype wire

// ===== design/stt_timer_match.sv
// match register and timer pending flag
`timescale 1ns/1ps
`default_nettype none
`include "stt_map.svh"
module stt_timer_match import stt_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// software write and counter
	input wire logic wr,
	input wire logic [31:0] wr_value,
	input wire logic [31:0] count,
	// results
	output logic [31:0] match_value,
	output logic pending
);
	typedef struct packed {
		logic [31:0] match;
		stt_tmr_state_type st;
	} stt_match_state_type;
	stt_match_state_type state_ff;
	stt_match_state_type nxt_state;
	logic hit;
	always_comb begin
		nxt_state = state_ff;
		hit = (count == state_ff.match);
		if (wr) begin
			nxt_state.match = wr_value;
		end
		case (state_ff.st)
			TMR_IDLE: begin
				if (hit && !wr) begin
					nxt_state.st = TMR_PEND;
				end
			end
			TMR_PEND: begin
				// clear wins only when no new hit lands in the same cycle
				if (wr && !(wr_value == count)) begin
					nxt_state.st = TMR_IDLE;
				end
			end
			default: begin
				nxt_state.st = TMR_IDLE;
			end
		endcase
		if (wr && (wr_value == count)) begin
			nxt_state.st = TMR_PEND;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= '{match: 32'hFFFFFFFF, st: TMR_IDLE};
		end else begin
			state_ff <= nxt_state;
		end
	end
	assign match_value = state_ff.match;
	assign pending = (state_ff.st == TMR_PEND);
endmodule : stt_timer_match
`default_nettype wire

// ===== verif/stt_core_model.sv
// core side model: fault capture, tlb exceptions, tlb reads and indexed writes
`timescale 1ns/1ps
`default_nettype none
module stt_core_model import stt_pkg::*; (
	// clock
	input wire logic clk,
	// strobes {cap, wide, exc, aderr, rd, wi} and payloads
	output logic [5:0] stb,
	output logic [47:0] insn,
	output logic [31:0] va
);
	initial begin
		stb = 6'h00;
		insn = 48'h0;
		va = 32'h0;
	end
	// payload inverted after the strobe so a stale value never passes for a live one
	task automatic pulse(input logic [5:0] s, input logic [47:0] i, input logic [31:0] a);
		@(posedge clk);
		stb <= s;
		insn <= i;
		va <= a;
		@(posedge clk);
		stb <= 6'h00;
		insn <= ~i;
		va <= ~a;
	endtask : pulse
endmodule : stt_core_model
`default_nettype wire

// ===== verif/stt_regs_properties.sv
// port assertions for the register slice
`timescale 1ns/1ps
`default_nettype none
module stt_regs_properties import stt_pkg::*; (
	// clock, reset and straps
	input wire logic MCLK, RST_B, SMALL_PAGE_SUPPORT, SMALL_PAGE_ENABLE, MEMORY_MAP_ID_MODE,
	input wire logic [1:0] TLB_INVALIDATE_SUPPORT,
	// register moves
	input wire logic MOVE_TO_SYS_REG, MOVE_FROM_SYS_REG, SYS_RVALID, USER_HW_REG_READ_OP,
	input wire logic [4:0] SYS_REG_NUM, USER_HW_REG_NUM,
	input wire logic [2:0] SYS_REG_SEL,
	input wire logic [31:0] SYS_WDATA, USER_HW_RDATA, COUNT_VALUE,
	// tlb and timer
	input wire logic TLB_EXCEPTION, TLB_READ_OP, TLB_WRITE_INDEXED_OP, TLB_WR_INVALIDATE, TIMER_IRQ_PENDING,
	input wire logic [31:0] FAULT_VADDR, TLB_ENTRY_TAG,
	input wire logic [18:0] TLB_RD_VPN,
	input wire logic [7:0] TLB_RD_ADDR_SPACE_TAG
);
	logic [31:0] mt_ff;
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	// shadow of the match value, the port set does not expose it
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) mt_ff <= 32'hFFFFFFFF;
		else if (MOVE_TO_SYS_REG && SYS_REG_NUM == 5'h0B && SYS_REG_SEL == 3'h0) mt_ff <= SYS_WDATA;
	end
	a_read_answer_once: assert property ($past(RST_B) |-> SYS_RVALID == $past(MOVE_FROM_SYS_REG))
		else $error("read answer not one cycle after request");
	a_user_count_read: assert property (USER_HW_REG_READ_OP && USER_HW_REG_NUM == 5'h02 |=>
		USER_HW_RDATA == COUNT_VALUE) else $error("user read of counter wrong");
	a_exc_page_copy: assert property (TLB_EXCEPTION && !TLB_READ_OP |=>
		TLB_ENTRY_TAG[31:13] == $past(FAULT_VADDR[31:13])) else $error("fault page not captured");
	a_tlb_read_load: assert property (TLB_READ_OP |=> TLB_ENTRY_TAG[31:13] == $past(TLB_RD_VPN) &&
		TLB_ENTRY_TAG[7:0] == ($past(MEMORY_MAP_ID_MODE) ? 8'h00 : $past(TLB_RD_ADDR_SPACE_TAG)))
		else $error("tlb read did not load tag");
	a_small_page_zero: assert property (!(SMALL_PAGE_SUPPORT && SMALL_PAGE_ENABLE) |->
		TLB_ENTRY_TAG[12:11] == 2'h0) else $error("page extension not zero");
	a_map_id_zero: assert property (MEMORY_MAP_ID_MODE |-> TLB_ENTRY_TAG[9:0] == 10'h000)
		else $error("space tags not zero in map id mode");
	a_write_invalidate: assert property ($past(RST_B) |-> TLB_WR_INVALIDATE == ($past(TLB_WRITE_INDEXED_OP) &&
		$past(TLB_ENTRY_TAG[10]) && TLB_INVALIDATE_SUPPORT > 2'h1)) else $error("invalidate strobe wrong");
	a_timer_match_set: assert property ($past(RST_B) && !$past(MOVE_TO_SYS_REG) && COUNT_VALUE == $past(mt_ff)
		|=> TIMER_IRQ_PENDING) else $error("timer pending not raised");
endmodule : stt_regs_properties
`default_nettype wire
bind stt_regs stt_regs_properties u_props (.MCLK, .RST_B, .SMALL_PAGE_SUPPORT, .SMALL_PAGE_ENABLE,
	.MEMORY_MAP_ID_MODE, .TLB_INVALIDATE_SUPPORT, .MOVE_TO_SYS_REG, .MOVE_FROM_SYS_REG, .SYS_RVALID,
	.USER_HW_REG_READ_OP, .SYS_REG_NUM, .USER_HW_REG_NUM, .SYS_REG_SEL, .SYS_WDATA, .USER_HW_RDATA, .COUNT_VALUE,
	.TLB_EXCEPTION, .TLB_READ_OP, .TLB_WRITE_INDEXED_OP, .TLB_WR_INVALIDATE, .TIMER_IRQ_PENDING, .FAULT_VADDR,
	.TLB_ENTRY_TAG, .TLB_RD_VPN, .TLB_RD_ADDR_SPACE_TAG);

// ===== verif/tb_top.sv
// self-checking bench for the register slice
`timescale 1ns/1ps
`default_nettype none
module tb_top import stt_pkg::*; ;
	logic MCLK = 1'b0, RST_B = 1'b0, pres = 1'b0, nof = 1'b0, ae = 1'b0, mmid = 1'b0, sp = 1'b0, spe = 1'b0;
	logic vec = 1'b0, mt = 1'b0, mf = 1'b0, hr = 1'b0, rv, hv, pend, req, winv;
	logic [1:0] isa = 2'h0, ie = 2'h0;
	logic [5:0] lvl = 6'h00, vlev, stb;
	logic [9:0] masid;
	logic [4:0] num = 5'h00;
	logic [2:0] sel = 3'h0;
	logic [31:0] wd = 32'h0, rdata, hdata, va, tag, cnt, v, e, texp;
	logic [47:0] insn;
	int bad_count = 0, checks_done = 0, n, ph;
	initial forever #50 MCLK = ~MCLK;
	stt_core_model core (.clk(MCLK), .stb(stb), .insn(insn), .va(va));
	stt_regs uut (.MCLK(MCLK), .RST_B(RST_B), .FAULT_INSN_PRESENT_FLAG(pres), .INSN_SET_SELECT(isa),
		.NO_FAULT_INSN_FLAG(nof), .TLB_INVALIDATE_SUPPORT(ie), .TAG_EXTENSION_ENABLE(ae), .MEMORY_MAP_ID_MODE(mmid),
		.SMALL_PAGE_SUPPORT(sp), .SMALL_PAGE_ENABLE(spe), .VECTORED_MODE(vec), .TIMER_IRQ_LEVEL(lvl),
		.MOVE_TO_SYS_REG(mt), .MOVE_FROM_SYS_REG(mf), .SYS_REG_NUM(num), .SYS_REG_SEL(sel), .SYS_WDATA(wd),
		.SYS_RDATA(rdata), .SYS_RVALID(rv), .USER_HW_REG_READ_OP(hr), .USER_HW_REG_NUM(num),
		.USER_HW_RDATA(hdata), .USER_HW_RVALID(hv), .FAULT_INSN_CAPTURE(stb[5]), .FAULT_INSN_WIDE(stb[4]),
		.FAULT_INSN(insn), .TLB_EXCEPTION(stb[3]), .ADDR_ERROR_EXCEPTION(stb[2]), .FAULT_VADDR(va),
		.TLB_READ_OP(stb[1]), .TLB_RD_VPN(va[31:13]), .TLB_RD_PPX(va[12:11]), .TLB_RD_INV(va[10]),
		.TLB_RD_ASX(va[9:8]), .TLB_RD_ADDR_SPACE_TAG(va[7:0]), .TLB_WRITE_INDEXED_OP(stb[0]), .TLB_ENTRY_TAG(tag),
		.TLB_MATCH_ADDR_SPACE_TAG(masid), .TLB_WR_INVALIDATE(winv), .TIMER_IRQ_PENDING(pend), .TIMER_IRQ_REQ(req),
		.TIMER_IRQ_VEC_LEVEL(vlev), .COUNT_VALUE(cnt));
	task automatic chk(input logic [31:0] x, input logic [31:0] g);
		checks_done++;
		if (g !== x) begin
			bad_count++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, x, g);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : test_done
	// w: move to, h: user read, else move from; answer sampled once it has landed
	task automatic bus(input logic w, h, input logic [4:0] r, input logic [2:0] s, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge MCLK);
		mt <= w;
		mf <= !w && !h;
		hr <= h;
		num <= r;
		sel <= s;
		wd <= d;
		@(posedge MCLK);
		{mt, mf, hr} <= 3'h0;
		wd <= ~d;
		#1 q = h ? hdata : rdata;
		if (!w) chk(32'h1, {31'h0, h ? hv : rv});
	endtask : bus
	function automatic logic [31:0] tmask(input logic [31:0] w);
		if (!(sp && spe)) w[12:11] = 2'h0;
		if (ie <= 2'h1) w[10] = 1'b0;
		if (!ae || mmid) w[9:8] = 2'h0;
		if (mmid) w[7:0] = 8'h00;
		return w;
	endfunction : tmask
	initial begin
		n = $urandom(10794);
		for (ph = 0; ph < 2; ph++) begin
			RST_B <= 1'b0;
			{pres, isa, nof, ie, ae, mmid, sp, spe, vec} <= ph == 0 ? 11'h757 : 11'h22C;
			lvl <= 6'($urandom);
			repeat (6) @(posedge MCLK);
			RST_B <= 1'b1;
			texp = 32'h0;
			v = $urandom;
			bus(1'b1, 1'b0, 5'h09, 3'h0, v, e);
			bus(1'b0, 1'b0, 5'h09, 3'h0, 32'h0, e);
			chk(v + 32'h1, e);
			bus(1'b0, 1'b1, 5'h02, 3'h0, 32'h0, e);
			chk(v + 32'h3, e);
			bus(1'b0, 1'b1, 5'h05, 3'h0, 32'h0, e);
			chk(32'h0, e);
			bus(1'b0, 1'b0, 5'h0C, 3'h0, 32'h0, e);
			chk(32'h0, e);
			v = $urandom;
			core.pulse(6'h30, {16'($urandom), v}, 32'h0);
			bus(1'b1, 1'b0, 5'h08, 3'h3, 32'hFFFFFFFF, e);
			bus(1'b0, 1'b0, 5'h08, 3'h3, 32'h0, e);
			chk(pres && isa == 2'h3 && !nof ? {v[15:0], 16'h0} : 32'h0, e);
			bus(1'b0, 1'b0, 5'h09, 3'h0, 32'h0, e);
			bus(1'b1, 1'b0, 5'h0B, 3'h0, e + 32'd20, v);
			bus(1'b0, 1'b0, 5'h0B, 3'h0, 32'h0, v);
			chk(e + 32'd20, v);
			for (n = 0; n < 40 && pend !== 1'b1; n++) @(posedge MCLK) #1;
			if (n == 40) begin
				bad_count++;
				test_done();
			end
			chk({25'h0, 1'b1, vec ? lvl : 6'h00}, {25'h0, req, vlev});
			bus(1'b1, 1'b0, 5'h0B, 3'h0, e, v);
			repeat (2) @(posedge MCLK) #1;
			chk(32'h0, {31'h0, pend});
			for (n = 0; n < 12; n++) begin
				v = $urandom;
				if (n % 3 == 0) begin
					core.pulse(6'h04, 48'h0, ~v);
					core.pulse(6'h08, 48'h0, v);
					texp = {v[31:11], texp[10:0]};
				end else if (n % 3 == 1) begin
					core.pulse(6'h02, 48'h0, v);
					texp = v;
				end else begin
					bus(1'b1, 1'b0, 5'h0A, 3'h0, v, e);
					texp = v;
				end
				texp = tmask(texp);
				bus(1'b0, 1'b0, 5'h0A, 3'h0, 32'h0, e);
				chk(texp, e);
				chk({22'h0, texp[9:0]}, {22'h0, masid});
				core.pulse(6'h01, 48'h0, ~v);
			end
		end
		test_done();
	end
endmodule : tb_top
`default_nettype wire
